// File: verification/i2c_link_monitor.sv
// wire-level checker for the two-wire link between master and slave
`timescale 1ns/100ps
module i2c_link_monitor
  import i2c_link_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, in_frame, desel, first;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic start_seen, stop_seen, rise, ninth, match;
  // raw wires come from flops, so no filtering needed here
  assign start_seen = scl && scl_q && sda_q && !sda;
  assign stop_seen = scl && scl_q && !sda_q && sda;
  assign rise = scl && !scl_q;
  assign ninth = rise && (bitcnt == 4'h8);
  assign match = (shreg[7:1] == SLAVE_ADDR) || (shreg == 8'h00);

  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      {scl_q, sda_q} <= 2'b11;
    else
      {scl_q, sda_q} <= {scl, sda};

  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      {in_frame, desel} <= 2'b00;
    else
    begin
      in_frame <= start_seen || (in_frame && !stop_seen);
      desel <= !start_seen && (desel || (ninth && first && !match));
    end

  // the stop's own scl rise is counted too; harmless, start clears it
  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      {first, bitcnt, shreg} <= 13'h0000;
    else if (start_seen)
      {first, bitcnt} <= 5'h10;
    else if (rise)
    begin
      first <= first && !ninth;
      bitcnt <= ninth ? 4'h0 : bitcnt + 4'h1;
      shreg <= ninth ? shreg : {shreg[6:0], sda};
    end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_quiet_outside_frame: assert property (!in_frame |-> !sda_s_oe)
    else $error("slave drives sda outside a frame");
  a_change_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved sda while scl high");
  a_ack_on_match: assert property (ninth && first |-> sda_s_oe == match)
    else $error("address acknowledge wrong");
  a_off_when_deselected: assert property (desel |-> !sda_s_oe)
    else $error("deselected slave drives sda");
  a_master_releases_ack: assert property (ninth && first |-> !sda_m_oe)
    else $error("master holds sda in address ack");
  a_scl_idle_high: assert property (!in_frame |-> scl)
    else $error("scl low outside a frame");
  a_scl_high_phase: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  a_release_after_nack: assert property (ninth && sda |=> !sda_s_oe[*8])
    else $error("slave drives sda after a nack");
endmodule

// File: verification/tb_i2c_slave_register_access.sv
// self-checking bench: master end drives the slave end across the link
`timescale 1ns/100ps
module tb_i2c_slave_register_access;
  localparam logic [9:0] S = 10'h000;
  localparam logic [9:0] P = 10'h300;
  localparam logic [9:0] RA = 10'h200;
  localparam logic [9:0] RN = 10'h201;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] cmd_data = 10'h000;
  logic cmd_valid = 1'b0;
  logic [1:0] addr_prog = 2'h2;
  logic cmd_ready, rx_valid, ack, busy, reg_wr, reg_rd, gcall_reset, xfer_done, idle_start;
  logic [7:0] rx_data, reg_addr, reg_wdata;
  logic [1:0] addr_latch;
  logic [7:0] mem [256];
  logic [7:0] wr_a [$];
  logic [7:0] wr_d [$];
  logic [7:0] rx_q [$];
  int n_fail = 0;
  int compares = 0;
  int n_done, n_idle, n_gc, n_refused, n_rd;

  always #12.5 mclk_i = ~mclk_i;

  i2c_link_if u_i2c_link_if ();
  // short divider keeps the run brief
  i2c_bus_master #(.HALF(10)) u_i2c_bus_master (.mclk_i(mclk_i), .reset_i(reset_i),
    .link(u_i2c_link_if), .cmd_data_i(cmd_data), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .ack_o(ack),
    .busy_o(busy));
  i2c_reg_slave u_i2c_reg_slave (.mclk_i(mclk_i), .reset_i(reset_i), .link(u_i2c_link_if),
    .addr_prog_i(addr_prog), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(mem[reg_addr]),
    .gcall_reset_o(gcall_reset), .addr_latch_o(addr_latch), .xfer_done_o(xfer_done),
    .idle_start_o(idle_start));
  i2c_link_monitor u_i2c_link_monitor (.mclk_i(mclk_i), .reset_i(reset_i),
    .scl(u_i2c_link_if.scl), .sda(u_i2c_link_if.sda), .sda_m_oe(u_i2c_link_if.sda_m_oe),
    .sda_s_oe(u_i2c_link_if.sda_s_oe));

  // register bank stand-in and event log
  always @(posedge mclk_i)
  begin
    if (reg_wr === 1'b1)
    begin
      wr_a.push_back(reg_addr);
      wr_d.push_back(reg_wdata);
      mem[reg_addr] <= reg_wdata;
    end
    if (rx_valid === 1'b1)
      rx_q.push_back(rx_data);
    n_done += int'(xfer_done === 1'b1);
    n_idle += int'(idle_start === 1'b1);
    n_gc += int'(gcall_reset === 1'b1);
    n_rd += int'(reg_rd === 1'b1);
  end

  function automatic logic [9:0] w(input logic [7:0] b);
    return {2'b01, b};
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // valid stays up between commands, dropped only after the last one
  task automatic push(input logic [9:0] c);
    cmd_data <= c;
    cmd_valid <= 1'b1;
    @(posedge mclk_i);
    while (cmd_ready !== 1'b1)
    begin
      n_refused++;
      @(posedge mclk_i);
    end
  endtask

  task automatic run(input logic [9:0] q[$]);
    int idle_len;
    foreach (q[i])
      push(q[i]);
    cmd_valid <= 1'b0;
    idle_len = 0;
    // busy rises only at the next idle divider tick, so demand a long quiet spell
    while (idle_len < 40)
    begin
      @(posedge mclk_i);
      idle_len = (busy === 1'b0) ? idle_len + 1 : 0;
    end
  endtask

  task automatic clr();
    wr_a.delete();
    wr_d.delete();
    rx_q.delete();
    n_done = 0;
    n_idle = 0;
    n_gc = 0;
    n_refused = 0;
    n_rd = 0;
  endtask

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #(25 * 60000);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    clr();
    run('{S, w(8'h80), w(8'h10), w(8'h5A), w(8'hC3), P});
    check("wcount", 8'h02, 8'(wr_a.size()));
    check("w0 addr", 8'h10, wr_a[0]);
    check("w0 data", 8'h5A, wr_d[0]);
    check("w1 addr", 8'h11, wr_a[1]);
    check("w1 data", 8'hC3, wr_d[1]);
    check("ack", 8'h01, {7'h00, ack});
    check("done", 8'h01, 8'(n_done));
    check("idle", 8'h01, 8'(n_idle));
    clr();
    run('{S, w(8'h80), w(8'h10), S, w(8'h81), RA, RN, P});
    check("rcount", 8'h02, 8'(rx_q.size()));
    check("r0", 8'h5A, rx_q[0]);
    check("r1", 8'hC3, rx_q[1]);
    check("rd wcount", 8'h00, 8'(wr_a.size()));
    check("rd done", 8'h01, 8'(n_done));
    check("rd strobes", 8'h02, 8'(n_rd));
    check("rd pointer", 8'h12, reg_addr);
    clr();
    run('{S, w(8'h80), w(8'h3B), w(8'h33), w(8'h44), P});
    check("n0 addr", 8'h3B, wr_a[0]);
    check("n1 addr", 8'h3B, wr_a[1]);
    check("n1 data", 8'h44, wr_d[1]);
    check("pointer", 8'h3B, reg_addr);
    clr();
    run('{S, w(8'h84), w(8'h77), P});
    check("miss ack", 8'h00, {7'h00, ack});
    check("miss wcount", 8'h00, 8'(wr_a.size()));
    check("miss idle", 8'h01, 8'(n_idle));
    check("miss done", 8'h00, 8'(n_done));
    clr();
    run('{S, P});
    run('{S, w(8'h80), w(8'h12), w(8'h99), P});
    check("after empty", 8'h01, 8'(wr_a.size()));
    check("after data", 8'h99, wr_d[0]);
    clr();
    run('{S, w(8'h00), w(8'h06), P});
    check("gc ack", 8'h01, {7'h00, ack});
    check("gc reset", 8'h01, 8'(n_gc));
    check("gc latch", 8'h02, {6'h00, addr_latch});
    addr_prog <= 2'h1;
    clr();
    run('{S, w(8'h00), w(8'h07), P});
    check("gc other", 8'h00, 8'(n_gc));
    check("gc keep", 8'h02, {6'h00, addr_latch});
    clr();
    run('{S, w(8'h80), w(8'h20), w(8'h01), w(8'h02), w(8'h03), w(8'h04), w(8'h05),
      w(8'h06), w(8'h07), P});
    check("fifo stall", 8'h01, 8'(n_refused > 0));
    check("fifo wcount", 8'h07, 8'(wr_a.size()));
    check("fifo last", 8'h26, wr_a[6]);
    print_verdict();
  end
endmodule

// File: verilog/i2c_bus_master.sv
// bus master end: runs byte commands from a fifo
`timescale 1ns/100ps
module i2c_bus_master
  import i2c_link_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  i2c_link_if.master link,
  input wire logic [9:0] cmd_data_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic ack_o,
  output logic busy_o
);
  // command word: [9:8] 00 start, 01 byte, 10 read (bit0 = nack), 11 stop
  logic [9:0] q_data;
  logic q_valid;
  logic q_ready;
  logic [15:0] div_reg;
  logic tick;
  logic [1:0] sda_sync;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] sh_reg;
  logic [1:0] op_reg;
  logic run_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  stream_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) cmd_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .flush_i(1'b0),
    .in_data_i(cmd_data_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .out_data_o(q_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_ready)
  );
  assign link.scl_m_oe = scl_oe_reg;
  assign link.sda_m_oe = sda_oe_reg;
  assign tick = (div_reg == 16'(HALF - 1));
  assign q_ready = !run_reg && tick;
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_reg <= 16'h0000;
      sda_sync <= 2'h3;
    end
    else
    begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      sda_sync <= {sda_sync[0], link.sda};
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      run_reg <= 1'b0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 9'h1FF;
      op_reg <= 2'h0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      ack_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (tick)
      begin
        if (!run_reg)
        begin
          busy_o <= q_valid;
          if (q_valid)
          begin
            run_reg <= 1'b1;
            op_reg <= q_data[9:8];
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            // reads shift out all ones plus the ack choice [RULE10]
            sh_reg <= q_data[9] ? {8'hFF, q_data[0]} : {q_data[7:0], 1'b1};
          end
        end
        else if (op_reg == 2'h0)
        begin
          // (re)start: raise both, then sda low while scl high [RULE2]
          // scl is left high; the next byte pulls it low itself
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            default: run_reg <= 1'b0;
          endcase
        end
        else if (op_reg == 2'h3)
        begin
          // stop: sda low, scl high, then sda high [RULE5]
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            default: run_reg <= 1'b0;
          endcase
        end
        else
        begin
          // data bits: change sda with scl low, sample at rise [RULE11]
          if (ph_reg == 2'h0)
          begin
            // fresh byte: scl low first so the first bit never meets a high scl
            scl_oe_reg <= 1'b1;
            ph_reg <= 2'h3;
          end
          else if (!scl_oe_reg)
          begin
            scl_oe_reg <= 1'b1;
            if (bit_reg == 4'h9)
            begin
              run_reg <= 1'b0;
              ph_reg <= 2'h0;
            end
          end
          else if (ph_reg == 2'h3)
          begin
            sda_oe_reg <= !sh_reg[8];
            ph_reg <= 2'h2;
          end
          else
          begin
            scl_oe_reg <= 1'b0;
            ph_reg <= 2'h3;
            sh_reg <= {sh_reg[7:0], sda_sync[1]};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7 && op_reg[1])
            begin
              rx_data_o <= {sh_reg[6:0], sda_sync[1]};
              rx_valid_o <= 1'b1;
            end
            if (bit_reg == 4'h8)
              ack_o <= !sda_sync[1];
          end
        end
      end
    end
  end
endmodule

// File: verilog/i2c_link_if.sv
// two-wire link joining bus master and slave
`timescale 1ns/100ps
interface i2c_link_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open drain: any enabled driver pulls low
  assign scl = !scl_m_oe;
  assign sda = !(sda_m_oe || sda_s_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface

// File: verilog/i2c_link_pkg.sv
// constants shared by the serial slave, the bus master and the link monitor
// Operation
// (RULE1) answer only slave address 40h
// (RULE2) start is sda falling while scl high
// (RULE3) ignore bus until a start seen
// (RULE4) start clears state, next byte is address
// (RULE5) stop is sda rising while scl high
// (RULE6) nack then stop returns to idle
// (RULE7) stop ends register writes of transaction
// (RULE8) start then stop leaves idle, no hang
// (RULE9) after stop release sda, flag transaction end
// (RULE10) transmitter releases, receiver acks ninth bit
// (RULE11) sample on scl rise, change while low
// (RULE12) eighth address bit one reads, zero writes
// (RULE13) ack own address, else stay off bus
// (RULE14) read: pointer write, restart, read, stop
// (RULE15) read bursts advance pointer in increment ranges
// (RULE16) non-incrementing ranges hold the pointer constant
// (RULE17) write: pointer then data, store and advance
// (RULE18) ack general call, take next byte as command
// (RULE19) command 06h resets and latches address bits
// (RULE20) no command 00h; other commands ignored
// (RULE21) works up to 400 kbps fast mode
// (RULE22) flag inactivity start on end or mismatch
// (RULE23) synchronise and filter scl and sda first
package i2c_link_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h40;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;
  localparam logic [7:0] GCALL_BAD = 8'h00;
  localparam int CLK_HZ = 40000000;
  localparam int FAST_BPS = 400000;
  localparam int STD_BPS = 100000;
  // master half-period count for fast mode
  localparam int HALF_CYCLES = CLK_HZ / (2 * FAST_BPS);
  localparam int FILTER_LEN = 3;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK = 3'b010,
    S_RX = 3'b011,
    S_TX = 3'b100,
    S_MACK = 3'b101,
    S_IGNORE = 3'b110
  } slv_state_t;
  // nonincrementing pointer ranges, e.g. a fifo or data port
  function automatic logic ptr_incr(input logic [7:0] ptr);
    return !(ptr >= 8'h3A && ptr <= 8'h3E);
  endfunction
endpackage

// File: verilog/i2c_reg_slave.sv
// serial slave end: bytes to register strobes
`timescale 1ns/100ps
module i2c_reg_slave
  import i2c_link_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  i2c_link_if.slave link,
  input wire logic [1:0] addr_prog_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic gcall_reset_o,
  output logic [1:0] addr_latch_o,
  output logic xfer_done_o,
  output logic idle_start_o
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [FILTER_LEN-1:0] scl_hist;
  logic [FILTER_LEN-1:0] sda_hist;
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  slv_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic rw_reg;
  logic gcall_reg;
  logic ptr_set_reg;
  logic sda_oe_reg;
  logic ack_reg;
  logic active_reg;
  // two stages, then a majority-free stable filter [RULE23]
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hist <= '1;
      sda_hist <= '1;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_hist <= {scl_hist[FILTER_LEN-2:0], scl_sync[1]};
      sda_hist <= {sda_hist[FILTER_LEN-2:0], sda_sync[1]};
      if (&scl_hist)
        scl_f <= 1'b1;
      else if (~|scl_hist)
        scl_f <= 1'b0;
      if (&sda_hist)
        sda_f <= 1'b1;
      else if (~|sda_hist)
        sda_f <= 1'b0;
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end
  // short filter keeps fast-mode bit time intact [RULE21]
  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;
  assign start_det = scl_f && scl_d && sda_d && !sda_f; // [RULE2]
  assign stop_det = scl_f && scl_d && !sda_d && sda_f; // [RULE5]
  assign link.sda_s_oe = sda_oe_reg;
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      rw_reg <= 1'b0;
      gcall_reg <= 1'b0;
      ptr_set_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      active_reg <= 1'b0;
      reg_addr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      gcall_reset_o <= 1'b0;
      addr_latch_o <= 2'h0;
      xfer_done_o <= 1'b0;
      idle_start_o <= 1'b0;
    end
    else
    begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      gcall_reset_o <= 1'b0;
      xfer_done_o <= 1'b0;
      idle_start_o <= 1'b0;
      if (start_det)
      begin
        // flush transfer state, pointer kept, next byte is address [RULE4]
        state_reg <= S_ADDR;
        bit_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
        gcall_reg <= 1'b0;
        ptr_set_reg <= 1'b0;
        active_reg <= 1'b1;
      end
      else if (stop_det)
      begin
        // release bus, end writes, report end [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
        state_reg <= S_IDLE;
        sda_oe_reg <= 1'b0;
        if (active_reg)
        begin
          xfer_done_o <= 1'b1;
          idle_start_o <= 1'b1; // [RULE22]
        end
        active_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_IDLE, S_IGNORE:
            sda_oe_reg <= 1'b0; // [RULE3] [RULE13]
          S_ADDR, S_RX:
          begin
            if (scl_rise) // [RULE11]
            begin
              shift_reg <= {shift_reg[6:0], sda_f};
              bit_reg <= bit_reg + 4'h1;
            end
            else if (scl_fall && bit_reg == 4'h8)
            begin
              bit_reg <= 4'h0;
              state_reg <= S_ACK;
              sda_oe_reg <= 1'b0;
              ack_reg <= 1'b0;
              if (state_reg == S_ADDR)
              begin
                rw_reg <= shift_reg[0]; // [RULE12]
                if (shift_reg[7:1] == SLAVE_ADDR) // [RULE1]
                begin
                  sda_oe_reg <= 1'b1; // [RULE13]
                  ack_reg <= 1'b1;
                  if (shift_reg[0])
                  begin
                    reg_rd_o <= 1'b1;
                  end
                end
                else if (shift_reg[7:1] == GCALL_ADDR && !shift_reg[0])
                begin
                  gcall_reg <= 1'b1; // [RULE18]
                  sda_oe_reg <= 1'b1;
                  ack_reg <= 1'b1;
                end
                else
                begin
                  state_reg <= S_IGNORE; // [RULE13]
                  idle_start_o <= 1'b1; // [RULE22]
                  active_reg <= 1'b0;
                end
              end
              else
              begin
                sda_oe_reg <= 1'b1; // [RULE10]
                ack_reg <= 1'b1;
                if (gcall_reg)
                begin
                  if (shift_reg == GCALL_RESET) // [RULE19]
                  begin
                    gcall_reset_o <= 1'b1;
                    addr_latch_o <= addr_prog_i;
                  end
                  // other commands, 00h included, do nothing [RULE20]
                end
                else if (!ptr_set_reg)
                begin
                  reg_addr_o <= shift_reg; // [RULE14]
                  ptr_set_reg <= 1'b1;
                end
                else
                begin
                  reg_wdata_o <= shift_reg; // [RULE17]
                  reg_wr_o <= 1'b1;
                end
              end
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_reg <= 1'b0;
              if (ack_reg && rw_reg && !gcall_reg)
              begin
                state_reg <= S_TX;
                sda_oe_reg <= !reg_rdata_i[7];
                shift_reg <= {reg_rdata_i[6:0], 1'b1};
                bit_reg <= 4'h1;
              end
              else
              begin
                state_reg <= S_RX;
                bit_reg <= 4'h0;
              end
            end
            else if (reg_wr_o && ptr_incr(reg_addr_o))
              reg_addr_o <= reg_addr_o + 8'h01; // [RULE17] [RULE16]
          end
          S_TX:
          begin
            // change data only while scl low [RULE11]
            if (scl_fall)
            begin
              if (bit_reg == 4'h8)
              begin
                sda_oe_reg <= 1'b0; // [RULE10]
                state_reg <= S_MACK;
                if (ptr_incr(reg_addr_o))
                  reg_addr_o <= reg_addr_o + 8'h01; // [RULE15] [RULE16]
              end
              else
              begin
                sda_oe_reg <= !shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b1};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          S_MACK:
          begin
            if (scl_rise)
            begin
              if (sda_f)
                state_reg <= S_IGNORE; // [RULE6]
              else
                reg_rd_o <= 1'b1; // [RULE15]
            end
            else if (scl_fall)
            begin
              state_reg <= S_TX;
              sda_oe_reg <= !reg_rdata_i[7];
              shift_reg <= {reg_rdata_i[6:0], 1'b1};
              bit_reg <= 4'h1;
            end
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// File: verilog/stream_fifo.sv
// valid/ready fifo with parameter width and depth
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign cnt = wp_reg - rp_reg;
  assign in_ready_o = (cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp_reg[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else if (flush_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + (AW+1)'(1);
      if (pop)
        rp_reg <= rp_reg + (AW+1)'(1);
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wp_reg[AW-1:0]] <= in_data_i;
  end
endmodule
